/* dv/pae_alarm_chk.sv */
// port assertions for the process alarm evaluator
`include "pae_defines.vh"
module pae_alarm_chk #(
   parameter SEC_CYCLES = 10
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata_q,
   input wire logic [2:0] aux_out_q,
   input wire logic [1:0] alarm_state_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [5:0] asg_q;
   logic [4:0] t1_q;
   logic [9:0] od1_q;
   logic [2:0] off_q;
   // ----------------------------------------
   // register mirror
   // ----------------------------------------
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         asg_q <= 6'h00;
         t1_q <= 5'h02;
         od1_q <= 10'h000;
         off_q <= 3'h0;
      end
      else
      begin
         if (reg_wr && reg_addr == `PAE_ADDR_ASSIGN) asg_q <= reg_wdata[5:0];
         if (reg_wr && reg_addr == 5'h08 && reg_wdata[4:0] <= 5'h11 && reg_wdata[4:0] != 5'h0C)
            t1_q <= reg_wdata[4:0];
         if (reg_wr && reg_addr == 5'h0E && reg_wdata[9:0] <= 10'h3E7) od1_q <= reg_wdata[9:0];
         if (t1_q != 5'h00) off_q <= 3'h0;
         else if (off_q != 3'h7) off_q <= off_q + 3'h1;
      end
   end
   function automatic logic route(input logic [1:0] s, input logic [1:0] st);
      return (s == 2'h1) ? st[0] : (s == 2'h2) ? st[1] : 1'b0;
   endfunction
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_unmapped_rd;
      reg_rd && (reg_addr == 5'h07 || reg_addr == 5'h0F || reg_addr > 5'h12);
   endsequence
   sequence s_delay_rd;
      reg_rd && (reg_addr inside {5'h05, 5'h06, 5'h0D, 5'h0E});
   endsequence
   sequence s_type_rd;
      reg_rd && (reg_addr == 5'h00 || reg_addr == 5'h08);
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
      else $error("read data not zero outside read cycle");
   a_unmapped_rd: assert property (s_unmapped_rd |=> reg_rdata_q == 16'h0000)
      else $error("unmapped read not zero");
   a_status_rd: assert property (reg_rd && reg_addr == `PAE_ADDR_STATUS |=>
      reg_rdata_q[15:7] == 9'h000)
      else $error("status spare bits set");
   a_delay_range: assert property (s_delay_rd |=> reg_rdata_q <= 16'h03E7)
      else $error("delay above range");
   a_type_range: assert property (s_type_rd |=> reg_rdata_q <= 16'h0011 &&
      !($past(reg_addr) == 5'h08 && reg_rdata_q == 16'h000C))
      else $error("bad type code held");
   a_first_out: assert property ($rose(resetn) |-> alarm_state_q == 2'h0 && aux_out_q == 3'h0)
      else $error("outputs set at reset release");
   a_aux_route: assert property ($stable(asg_q) |-> aux_out_q == {route(asg_q[5:4],
      alarm_state_q), route(asg_q[3:2], alarm_state_q), route(asg_q[1:0], alarm_state_q)})
      else $error("aux output not following assignment");
   a_type_off: assert property (off_q > 3'h3 && od1_q == 10'h000 |-> !alarm_state_q[1])
      else $error("disabled channel alarming");
endmodule // pae_alarm_chk
bind pae_alarm pae_alarm_chk #(.SEC_CYCLES(SEC_CYCLES)) i_pae_alarm_chk (.clk(clk),
   .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .aux_out_q(aux_out_q),
   .alarm_state_q(alarm_state_q));

/* dv/pae_alarm_tb.sv */
// self-checking bench for the process alarm evaluator
`include "pae_defines.vh"
module pae_alarm_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic heater_model = 1'b1;
   logic ha_t = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000, pv_t = 16'h0000, sp_t = 16'h0000;
   logic [15:0] mv_t = 16'h0000, cv_t = 16'h0000, rv;
   wire [15:0] reg_rdata_q, process_value, set_point, manipulated_variable, cooling_variable;
   wire set_point_change, loop_burnout_alarm, heater_alarm;
   wire [2:0] aux_out_q;
   wire [1:0] alarm_state_q;
   int mismatches = 0, n_checks = 0, cyc = 0;
   int m_type = 2, m_x = 0, m_l = 0, m_h = 0, m_hy = 1, m_pv = 0, m_sp = 0, m_mv = 0, m_cv = 0;
   bit m_up, m_dn, m_hc, m_sb = 1'b1;
   int tl[17] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 13, 14, 15, 16, 17};
   logic [4:0] ra[16] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h10, 5'h11,
      5'h08, 5'h08, 5'h08, 5'h08, 5'h0D, 5'h0D, 5'h0D};
   logic [15:0] rw[16] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'h000C, 16'h0012, 16'h0011, 16'h0002, 16'h03E8, 16'h03E7, 16'h0000};
   logic [15:0] re[16] = '{16'h0002, 16'h0, 16'h0, 16'h0, 16'h0001, 16'h0, 16'h0, 16'h0, 16'h0,
      16'h0002, 16'h0002, 16'h0011, 16'h0002, 16'h0000, 16'h03E7, 16'h0000};
   int hs[5] = '{100, 96, 94, 99, 100};
   int sbp[5] = '{150, 10, 150, 150, 0};
   int sbs[5] = '{0, 0, 0, 5, 5};
   pae_loop_model i_pae_loop_model (.clk(clk), .pv_t(pv_t), .sp_t(sp_t), .mv_t(mv_t),
      .cv_t(cv_t), .ha_t(ha_t), .process_value(process_value), .set_point(set_point),
      .set_point_change(set_point_change), .manipulated_variable(manipulated_variable),
      .cooling_variable(cooling_variable), .heater_alarm(heater_alarm),
      .loop_burnout_alarm(loop_burnout_alarm));
   pae_alarm #(.SEC_CYCLES(10)) i_pae_alarm (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .process_value(process_value), .set_point(set_point), .set_point_change(set_point_change),
      .manipulated_variable(manipulated_variable), .cooling_variable(cooling_variable),
      .loop_burnout_alarm(loop_burnout_alarm), .heater_alarm(heater_alarm),
      .heater_model(heater_model), .aux_out_q(aux_out_q), .alarm_state_q(alarm_state_q));
   // ----------------------------------------
   // bus, compare and model
   // ----------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rchk(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata_q;
      if (e !== 16'hFFFF) chk(rv, e);
   endtask
   task wtype(input int t);
      wr(5'h08, t[15:0]);
      m_type = t;
      m_sb = 1'b1;
   endtask
   function automatic int rs(input int a);
      return int'($urandom % (2 * a + 1)) - a;
   endfunction
   function automatic bit fl(input bit f, input int v, input int t, input bit up, input bit st);
      if (f) return up ? v >= t - m_hy : v <= t + m_hy;
      if (up) return st ? v > t : v >= t;
      return st ? v < t : v <= t;
   endfunction
   task model(output bit r);
      int c, s, tu, td;
      bit nu, nd, st;
      c = (m_hc && m_type == 17) ? m_cv : m_mv;
      {s, tu, td, st} = {m_pv, m_sp + m_x, m_sp - m_x, 1'b0};
      r = 1'b0;
      case (m_type)
         1, 4, 5: {tu, td} = {m_sp + m_h, m_sp - m_l};
         8, 9, 10, 11: {tu, td, st} = {m_x, m_x, 1'b1};
         14, 15: {s, tu, td, st} = {m_sp, m_x, m_x, 1'b1};
         16, 17: {s, tu, td, st} = {c, m_x, m_x, 1'b1};
         default: ;
      endcase
      nu = fl(m_up, s, tu, 1'b1, st);
      nd = fl(m_dn, s, td, 1'b0, st);
      if (m_type inside {1, 5}) r = nu | nd;
      if (m_type == 4) r = !nu && !nd;
      if (m_type inside {2, 6, 8, 10, 14, 16}) r = nu;
      if (m_type inside {3, 7, 9, 11, 15, 17}) r = nd;
      if (m_type == 5 && m_h - m_hy <= m_hy - m_l) r = 1'b0;
      if (m_hc && m_x < 0 && m_type inside {16, 17}) r = 1'b1;
      if (!r) m_sb = 1'b0;
      if (m_sb && m_type inside {5, 6, 7, 10, 11}) r = 1'b0;
      m_up = nu;
      m_dn = nd;
   endtask
   task setv(input int p, input int s, input int m, input int c);
      bit e;
      @(posedge clk);
      pv_t <= p[15:0];
      sp_t <= s[15:0];
      mv_t <= m[15:0];
      cv_t <= c[15:0];
      model(e);
      if (s != m_sp) m_sb = 1'b1;
      {m_pv, m_sp, m_mv, m_cv} = {p, s, m, c};
      repeat (6) @(posedge clk);
      #1;
      model(e);
      chk(alarm_state_q[1], e);
      chk(aux_out_q, {1'b0, e, e});
      chk(alarm_state_q[0], ha_t);
   endtask
   task dly(input int v, input logic a, input logic b);
      @(posedge clk);
      pv_t <= v[15:0];
      repeat (6) @(posedge clk);
      #1;
      chk(alarm_state_q[1], a);
      repeat (40) @(posedge clk);
      #1;
      chk(alarm_state_q[1], b);
      m_pv = v;
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // clock, timeout, sequence
   // ----------------------------------------
   initial forever #2 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         results();
      end
   end
   initial
   begin
      void'($urandom(17536));
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 9; i++) rchk(ra[i], re[i]);
      rchk(5'h00, 16'h0000);
      rchk(`PAE_ADDR_STATUS, 16'hFFFF);
      chk(rv[6], 1'b1);
      rchk(5'h07, 16'h0000);
      rchk(5'h1F, 16'h0000);
      ha_t <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk(alarm_state_q[0], 1'b1);
      chk(aux_out_q, 3'h0);
      wr(`PAE_ADDR_ASSIGN, 16'h0001);
      rchk(5'h00, 16'h0002);
      wr(5'h00, 16'h000C);
      rchk(5'h00, 16'h000C);
      for (int i = 9; i < 16; i++)
      begin
         wr(ra[i], rw[i]);
         rchk(ra[i], re[i]);
      end
      wr(`PAE_ADDR_ASSIGN, 16'h000A);
      setv(-100, 0, 0, 0);
      wr(5'h0D, 16'h0002);
      wr(5'h0E, 16'h0002);
      dly(100, 1'b0, 1'b1);
      dly(-100, 1'b1, 1'b0);
      wr(5'h0D, 16'h0000);
      wr(5'h0E, 16'h0000);
      wr(5'h0C, 16'h0005);
      wr(5'h09, 16'h0064);
      {m_hy, m_x} = {32'd5, 32'd100};
      foreach (hs[i]) setv(hs[i], 0, 0, 0);
      wr(5'h0C, 16'h0001);
      m_hy = 1;
      wtype(6);
      foreach (sbp[i]) setv(sbp[i], sbs[i], 0, 0);
      wr(5'h0B, 16'h0001);
      {m_h, m_l} = {32'd1, 32'd0};
      wtype(5);
      setv(500, 0, 0, 0);
      wr(`PAE_ADDR_CTRL, 16'h0001);
      wr(5'h09, 16'hFFFB);
      {m_hc, m_x} = {1'b1, -32'sd5};
      wtype(17);
      setv(0, 0, 0, 100);
      wtype(16);
      setv(0, 0, -100, 0);
      repeat (30)
      begin
         {m_x, m_l, m_h} = {rs(600), int'($urandom % 600), int'($urandom % 600)};
         m_hc = $urandom % 2;
         wr(5'h09, m_x[15:0]);
         wr(5'h0A, m_l[15:0]);
         wr(5'h0B, m_h[15:0]);
         wr(`PAE_ADDR_CTRL, {15'h0000, m_hc});
         wtype(tl[$urandom % 17]);
         repeat (3) setv(rs(1000), rs(1000), rs(1000), rs(1000));
      end
      wtype(0);
      setv(500, 0, 0, 0);
      results();
   end
endmodule // pae_alarm_tb

/* dv/pae_loop_model.sv */
// control loop side: registers values, flags set point moves
module pae_loop_model (
   input wire logic clk,
   input wire logic [15:0] pv_t,
   input wire logic [15:0] sp_t,
   input wire logic [15:0] mv_t,
   input wire logic [15:0] cv_t,
   input wire logic ha_t,
   output logic [15:0] process_value,
   output logic [15:0] set_point,
   output logic set_point_change,
   output logic [15:0] manipulated_variable,
   output logic [15:0] cooling_variable,
   output logic heater_alarm,
   output logic loop_burnout_alarm
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {process_value, set_point, manipulated_variable, cooling_variable} = 64'h0;
      {set_point_change, heater_alarm, loop_burnout_alarm} = 3'h0;
   end
   always @(posedge clk)
   begin
      process_value <= pv_t;
      set_point <= sp_t;
      set_point_change <= (sp_t != set_point);
      manipulated_variable <= mv_t;
      cooling_variable <= cv_t;
      heater_alarm <= ha_t;
      loop_burnout_alarm <= ha_t;
   end
endmodule // pae_loop_model

/* rtl/pae_alarm.v */
// process alarm evaluator top level
`include "pae_defines.vh"
// What this block does
// - every channel keeps its own type code, off or one of seventeen types (sixteen on channel 2, no type 12)
// - after reset each channel type code is 2, deviation upper limit
// - each channel has on and off delays of 0 to 999 seconds
// - aux outputs follow only the channel assigned to them
// - heater models: channel 1 is heater alarm, type hidden until assigned
// - type 1: alarm when value outside set point minus L to plus H
// - type 2: alarm when value at or above set point plus signed X
// - type 3: alarm when value at or below set point minus X
// - type 4: alarm when value inside set point minus L to plus H
// - types 1, 4, 5 keep separate lower and upper limits
// - types 5, 6, 7 act as 1, 2, 3 plus standby
// - type 5 stays off while upper and lower hysteresis regions overlap
// - type 8: alarm when process value above X, set point ignored
// - type 9: alarm when process value below X, set point ignored
// - types 10, 11 act as 8, 9 plus standby
// - type 12, loop burnout, accepted by channel 1 only
// - type 14: alarm when set point above X
// - type 15: alarm when set point below X
// - type 16: alarm when manipulated variable above X
// - type 17: alarm when manipulated variable below X
// - heat/cool: 16 uses heating, 17 cooling, negative X always on
module pae_alarm #(
   parameter SEC_CYCLES = `PAE_SECOND_NS / `PAE_CLK_PERIOD_NS
) (
   input wire clk,
   input wire resetn,
   input wire [`PAE_AW-1:0] reg_addr,
   input wire [`PAE_DW-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`PAE_DW-1:0] reg_rdata_q,
   input wire [`PAE_DW-1:0] process_value,
   input wire [`PAE_DW-1:0] set_point,
   input wire set_point_change,
   input wire [`PAE_DW-1:0] manipulated_variable,
   input wire [`PAE_DW-1:0] cooling_variable,
   input wire loop_burnout_alarm,
   input wire heater_alarm,
   input wire heater_model,
   output reg [`PAE_NAUX-1:0] aux_out_q,
   output reg [`PAE_NCH-1:0] alarm_state_q
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function reg_hit;
      input [`PAE_AW-1:0] a;
      input [`PAE_AW-1:0] base;
      input [`PAE_AW-1:0] off;
      begin
         reg_hit = (a == base + off);
      end
   endfunction

   function type_ok;
      input [`PAE_TW-1:0] code;
      input first_ch;
      begin
         type_ok = (code <= `PAE_T_MV_DN) && ((code != `PAE_T_LOOP) || first_ch);
      end
   endfunction

   function has_standby;
      input [`PAE_TW-1:0] code;
      begin
         has_standby = (code == `PAE_T_BAND_OUT_SB) || (code == `PAE_T_DEV_UP_SB) ||
            (code == `PAE_T_DEV_DN_SB) || (code == `PAE_T_ABS_UP_SB) ||
            (code == `PAE_T_ABS_DN_SB);
      end
   endfunction

   function is_band;
      input [`PAE_TW-1:0] code;
      begin
         is_band = (code == `PAE_T_BAND_OUT) || (code == `PAE_T_BAND_IN) ||
            (code == `PAE_T_BAND_OUT_SB);
      end
   endfunction

   function pick;
      input [1:0] sel;
      input [`PAE_NCH-1:0] ch;
      begin
         case (sel)
            2'h1: pick = ch[0];
            2'h2: pick = ch[1];
            default: pick = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------
   // one second tick
   // ----------------------------------------
   reg [27:0] div_q;
   reg sec_tick_q;
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         div_q <= 28'h0000000;
         sec_tick_q <= 1'b0;
      end
      else if (div_q == SEC_CYCLES[27:0] - 28'h0000001)
      begin
         div_q <= 28'h0000000;
         sec_tick_q <= 1'b1;
      end
      else
      begin
         div_q <= div_q + 28'h0000001;
         sec_tick_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // global registers
   // ----------------------------------------
   reg [5:0] assign_q;
   reg heat_cool_q;
   reg armed_q;
   reg heater_mode_q;
   wire assign_wr;
   wire [`PAE_NCH-1:0] raw;
   wire [`PAE_NCH-1:0] stby;
   wire [`PAE_NCH-1:0] dly_out;
   wire [`PAE_DW-1:0] ch_rd0;
   wire [`PAE_DW-1:0] ch_rd1;
   wire [`PAE_DW-1:0] ch_rd [0:`PAE_NCH-1];

   assign assign_wr = reg_wr && (reg_addr == `PAE_ADDR_ASSIGN);

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         assign_q <= `PAE_RST_ASSIGN;
         heat_cool_q <= 1'b0;
         armed_q <= 1'b0;
         heater_mode_q <= 1'b0;
      end
      else
      begin
         armed_q <= 1'b1;
         if (assign_wr)
            assign_q <= reg_wdata[5:0];
         if (reg_wr && (reg_addr == `PAE_ADDR_CTRL))
            heat_cool_q <= reg_wdata[0];
         // strap taken on first edge after release
         if (!armed_q)
            heater_mode_q <= heater_model;
         else if (assign_wr && ((reg_wdata[1:0] == 2'h1) || (reg_wdata[3:2] == 2'h1) ||
            (reg_wdata[5:4] == 2'h1)))
            heater_mode_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // alarm channels
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `PAE_NCH; gi = gi + 1)
      begin : g_ch
         localparam [`PAE_AW-1:0] BASE = (gi == 0) ? `PAE_CH0_BASE : `PAE_CH1_BASE;
         localparam FIRST = (gi == 0);
         reg [`PAE_TW-1:0] type_q;
         reg [`PAE_DW-1:0] xval_q;
         reg [`PAE_DW-1:0] low_q;
         reg [`PAE_DW-1:0] high_q;
         reg [`PAE_DW-1:0] hyst_q;
         reg [`PAE_DLYW-1:0] on_dly_q;
         reg [`PAE_DLYW-1:0] off_dly_q;
         reg up_q;
         reg dn_q;
         reg sb_q;
         reg [`PAE_DW-1:0] rd_d;
         reg signed [17:0] subj;
         reg signed [17:0] thr_up;
         reg signed [17:0] thr_dn;
         reg strict;
         reg res;
         reg up_d;
         reg dn_d;
         wire signed [17:0] pv_s;
         wire signed [17:0] sp_s;
         wire signed [17:0] x_s;
         wire signed [17:0] hy_s;
         wire type_wr;
         wire hidden;

         assign pv_s = {{2{process_value[15]}}, process_value};
         assign sp_s = {{2{set_point[15]}}, set_point};
         assign x_s = {{2{xval_q[15]}}, xval_q};
         assign hy_s = {2'b00, hyst_q};
         assign type_wr = reg_wr && reg_hit(reg_addr, BASE, `PAE_OFF_TYPE);
         assign hidden = FIRST && heater_mode_q;

         // register writes
         always @(posedge clk or negedge resetn)
         begin
            if (!resetn)
            begin
               type_q <= `PAE_RST_TYPE;
               xval_q <= `PAE_RST_VAL;
               low_q <= `PAE_RST_VAL;
               high_q <= `PAE_RST_VAL;
               hyst_q <= `PAE_RST_HYST;
               on_dly_q <= `PAE_RST_DLY;
               off_dly_q <= `PAE_RST_DLY;
            end
            else if (reg_wr)
            begin
               if (type_wr && type_ok(reg_wdata[4:0], FIRST))
                  type_q <= reg_wdata[4:0];
               if (reg_hit(reg_addr, BASE, `PAE_OFF_XVAL))
                  xval_q <= reg_wdata;
               if (reg_hit(reg_addr, BASE, `PAE_OFF_LOW))
                  low_q <= reg_wdata;
               if (reg_hit(reg_addr, BASE, `PAE_OFF_HIGH))
                  high_q <= reg_wdata;
               if (reg_hit(reg_addr, BASE, `PAE_OFF_HYST))
                  hyst_q <= reg_wdata;
               if (reg_hit(reg_addr, BASE, `PAE_OFF_ON_DLY) && reg_wdata[9:0] <= `PAE_DLY_MAX)
                  on_dly_q <= reg_wdata[9:0];
               if (reg_hit(reg_addr, BASE, `PAE_OFF_OFF_DLY) && reg_wdata[9:0] <= `PAE_DLY_MAX)
                  off_dly_q <= reg_wdata[9:0];
            end
         end

         // subject and thresholds
         always @*
         begin
            subj = pv_s;
            strict = 1'b0;
            thr_up = sp_s + (is_band(type_q) ? {{2{high_q[15]}}, high_q} : x_s);
            thr_dn = sp_s - (is_band(type_q) ? {{2{low_q[15]}}, low_q} : x_s);
            case (type_q)
               `PAE_T_ABS_UP, `PAE_T_ABS_DN, `PAE_T_ABS_UP_SB, `PAE_T_ABS_DN_SB:
               begin
                  strict = 1'b1;
                  thr_up = x_s;
                  thr_dn = x_s;
               end
               `PAE_T_SP_UP, `PAE_T_SP_DN:
               begin
                  subj = sp_s;
                  strict = 1'b1;
                  thr_up = x_s;
                  thr_dn = x_s;
               end
               `PAE_T_MV_UP:
               begin
                  subj = {{2{manipulated_variable[15]}}, manipulated_variable};
                  strict = 1'b1;
                  thr_up = x_s;
                  thr_dn = x_s;
               end
               `PAE_T_MV_DN:
               begin
                  subj = heat_cool_q ? {{2{cooling_variable[15]}}, cooling_variable} :
                     {{2{manipulated_variable[15]}}, manipulated_variable};
                  strict = 1'b1;
                  thr_up = x_s;
                  thr_dn = x_s;
               end
               default:
               begin
                  subj = pv_s;
               end
            endcase
            // hysteresis on both comparison flags
            if (up_q)
               up_d = !(subj < thr_up - hy_s);
            else
               up_d = strict ? (subj > thr_up) : (subj >= thr_up);
            if (dn_q)
               dn_d = !(subj > thr_dn + hy_s);
            else
               dn_d = strict ? (subj < thr_dn) : (subj <= thr_dn);
         end

         // result by type
         always @*
         begin
            case (type_q)
               `PAE_T_BAND_OUT, `PAE_T_BAND_OUT_SB:
               begin
                  res = up_q || dn_q;
                  if ((type_q == `PAE_T_BAND_OUT_SB) && (thr_up - hy_s <= thr_dn + hy_s))
                     res = 1'b0;
               end
               `PAE_T_DEV_UP, `PAE_T_DEV_UP_SB, `PAE_T_ABS_UP, `PAE_T_ABS_UP_SB,
               `PAE_T_SP_UP:
                  res = up_q;
               `PAE_T_DEV_DN, `PAE_T_DEV_DN_SB, `PAE_T_ABS_DN, `PAE_T_ABS_DN_SB,
               `PAE_T_SP_DN:
                  res = dn_q;
               `PAE_T_BAND_IN:
                  res = !up_q && !dn_q;
               `PAE_T_LOOP:
                  res = FIRST && loop_burnout_alarm;
               `PAE_T_MV_UP:
                  res = up_q || (heat_cool_q && xval_q[15]);
               `PAE_T_MV_DN:
                  res = dn_q || (heat_cool_q && xval_q[15]);
               default:
                  res = 1'b0;
            endcase
            if (hidden)
               res = heater_alarm;
         end

         // flags and standby
         always @(posedge clk or negedge resetn)
         begin
            if (!resetn)
            begin
               up_q <= 1'b0;
               dn_q <= 1'b0;
               sb_q <= 1'b1;
            end
            else
            begin
               up_q <= up_d;
               dn_q <= dn_d;
               if (set_point_change || type_wr)
                  sb_q <= 1'b1;
               else if (!res)
                  sb_q <= 1'b0;
            end
         end

         assign stby[gi] = sb_q;
         assign raw[gi] = res && !(has_standby(type_q) && sb_q && !hidden);

         // read mux
         always @*
         begin
            rd_d = {`PAE_DW{1'b0}};
            if (reg_hit(reg_addr, BASE, `PAE_OFF_TYPE))
               rd_d = hidden ? {`PAE_DW{1'b0}} : {11'h000, type_q};
            else if (reg_hit(reg_addr, BASE, `PAE_OFF_XVAL))
               rd_d = xval_q;
            else if (reg_hit(reg_addr, BASE, `PAE_OFF_LOW))
               rd_d = low_q;
            else if (reg_hit(reg_addr, BASE, `PAE_OFF_HIGH))
               rd_d = high_q;
            else if (reg_hit(reg_addr, BASE, `PAE_OFF_HYST))
               rd_d = hyst_q;
            else if (reg_hit(reg_addr, BASE, `PAE_OFF_ON_DLY))
               rd_d = {6'h00, on_dly_q};
            else if (reg_hit(reg_addr, BASE, `PAE_OFF_OFF_DLY))
               rd_d = {6'h00, off_dly_q};
         end
         assign ch_rd[gi] = rd_d;

         pae_delay u_dly (
            .clk(clk),
            .resetn(resetn),
            .sec_tick(sec_tick_q),
            .raw(raw[gi]),
            .on_dly(on_dly_q),
            .off_dly(off_dly_q),
            .out_q(dly_out[gi])
         );
      end
   endgenerate

   assign ch_rd0 = ch_rd[0];
   assign ch_rd1 = ch_rd[1];

   // ----------------------------------------
   // outputs and read data
   // ----------------------------------------
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         aux_out_q <= {`PAE_NAUX{1'b0}};
         alarm_state_q <= {`PAE_NCH{1'b0}};
         reg_rdata_q <= {`PAE_DW{1'b0}};
      end
      else
      begin
         aux_out_q[0] <= pick(assign_q[1:0], dly_out);
         aux_out_q[1] <= pick(assign_q[3:2], dly_out);
         aux_out_q[2] <= pick(assign_q[5:4], dly_out);
         alarm_state_q <= dly_out;
         if (!reg_rd)
            reg_rdata_q <= {`PAE_DW{1'b0}};
         else if (reg_addr == `PAE_ADDR_ASSIGN)
            reg_rdata_q <= {10'h000, assign_q};
         else if (reg_addr == `PAE_ADDR_CTRL)
            reg_rdata_q <= {15'h0000, heat_cool_q};
         else if (reg_addr == `PAE_ADDR_STATUS)
            reg_rdata_q <= {9'h000, heater_mode_q, stby, dly_out, raw};
         else
            reg_rdata_q <= ch_rd0 | ch_rd1;
      end
   end
endmodule // pae_alarm

/* rtl/pae_defines.vh */
// constants for the process alarm evaluator
`ifndef PAE_DEFINES_VH
`define PAE_DEFINES_VH
// ----------------------------------------
// sizes
// ----------------------------------------
`define PAE_AW 5
`define PAE_DW 16
`define PAE_TW 5
`define PAE_DLYW 10
`define PAE_NCH 2
`define PAE_NAUX 3
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PAE_CH0_BASE 5'h00
`define PAE_CH1_BASE 5'h08
`define PAE_OFF_TYPE 5'h00
`define PAE_OFF_XVAL 5'h01
`define PAE_OFF_LOW 5'h02
`define PAE_OFF_HIGH 5'h03
`define PAE_OFF_HYST 5'h04
`define PAE_OFF_ON_DLY 5'h05
`define PAE_OFF_OFF_DLY 5'h06
`define PAE_ADDR_ASSIGN 5'h10
`define PAE_ADDR_CTRL 5'h11
`define PAE_ADDR_STATUS 5'h12
// ----------------------------------------
// reset values
// ----------------------------------------
`define PAE_RST_TYPE 5'h02
`define PAE_RST_VAL 16'h0000
`define PAE_RST_HYST 16'h0001
`define PAE_RST_DLY 10'h000
`define PAE_RST_ASSIGN 6'h00
// ----------------------------------------
// alarm type codes
// ----------------------------------------
`define PAE_T_OFF 5'h00
`define PAE_T_BAND_OUT 5'h01
`define PAE_T_DEV_UP 5'h02
`define PAE_T_DEV_DN 5'h03
`define PAE_T_BAND_IN 5'h04
`define PAE_T_BAND_OUT_SB 5'h05
`define PAE_T_DEV_UP_SB 5'h06
`define PAE_T_DEV_DN_SB 5'h07
`define PAE_T_ABS_UP 5'h08
`define PAE_T_ABS_DN 5'h09
`define PAE_T_ABS_UP_SB 5'h0A
`define PAE_T_ABS_DN_SB 5'h0B
`define PAE_T_LOOP 5'h0C
`define PAE_T_RATE 5'h0D
`define PAE_T_SP_UP 5'h0E
`define PAE_T_SP_DN 5'h0F
`define PAE_T_MV_UP 5'h10
`define PAE_T_MV_DN 5'h11
// ----------------------------------------
// timing
// ----------------------------------------
`define PAE_CLK_PERIOD_NS 4
`define PAE_SECOND_NS 1000000000
`define PAE_DLY_MAX 10'h3E7
`endif

/* rtl/pae_delay.v */
// on/off delay stage for one alarm channel
`include "pae_defines.vh"
module pae_delay (
   input wire clk,
   input wire resetn,
   input wire sec_tick,
   input wire raw,
   input wire [`PAE_DLYW-1:0] on_dly,
   input wire [`PAE_DLYW-1:0] off_dly,
   output reg out_q
);
   reg [`PAE_DLYW-1:0] cnt_q;
   wire [`PAE_DLYW-1:0] target;

   assign target = raw ? on_dly : off_dly;

   // ----------------------------------------
   // delay counter
   // ----------------------------------------
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         out_q <= 1'b0;
         cnt_q <= `PAE_RST_DLY;
      end
      else if (raw == out_q)
      begin
         cnt_q <= `PAE_RST_DLY;
      end
      else if (cnt_q >= target)
      begin
         out_q <= raw;
         cnt_q <= `PAE_RST_DLY;
      end
      else if (sec_tick)
      begin
         cnt_q <= cnt_q + 10'h001;
      end
   end
endmodule // pae_delay
